// *** rtl/lpt_consts.svh ***
// Offsets, field positions, reset values and codes of the link packet transmitter.
// Assumes an 8-bit register port; included by link_packet_tx and lpt_properties by bare name.
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH

`define LPT_CFG_ADDR   8'hA8
`define LPT_UTH_ADDR   8'hA9
`define LPT_LTH_ADDR   8'hAA
`define LPT_IEN_ADDR   8'hAB
`define LPT_IST_ADDR   8'hAC
`define LPT_TXB_ADDR   8'hAD

`define LPT_B_SHARE    7
`define LPT_B_FLUSH    6
`define LPT_B_REPORT_INSERT_ENABLE     5
`define LPT_B_EOM      3
`define LPT_B_ABT      2
`define LPT_B_CRC      1
`define LPT_B_EN       0

`define LPT_B_UNDER    1
`define LPT_CFG_MASK   8'hEF
`define LPT_CFG_RST    8'h82
`define LPT_UTH_RST    7'h40
`define LPT_LTH_RST    7'h07
`define LPT_IEN_RST    5'h00
`define LPT_IST_ALL    5'h1F

`define LPT_FLAG       16'h007E
`define LPT_ABORT      16'h00FE
`define LPT_CRC_POLY   16'h1021
`define LPT_CRC_INIT   16'hFFFF
`define LPT_BYTE_BITS  5'd8
`define LPT_FCS_BITS   5'd16
`define LPT_STUFF_RUN  3'd5

`endif

// *** rtl/lpt_pkg.sv ***
// Types shared by the link packet transmitter.
// Assumes nothing beyond a SystemVerilog compiler.
package lpt_pkg;

	typedef enum logic [1:0] {TX_IDLE, TX_BODY, TX_FCS} tx_state_t;

endpackage

// *** rtl/queue_mem_if.sv ***
// Carrier between the transmitter and its queue memory.
// Assumes one write port and one registered read port.
interface queue_mem_if #(
	parameter int AW = 7,
	parameter int DW = 8
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport user  (output we, waddr, wdata, raddr, input rdata);
	modport store (input we, waddr, wdata, raddr, output rdata);
endinterface

// *** rtl/queue_mem.sv ***
// Byte store for the transmit queue; read data come from a register.
// Assumes the user keeps the read address steady a cycle before using rdata.
module queue_mem #(
	parameter int AW = 7,
	parameter int DW = 8
)(
	input  wire logic sys_clk_i,
	queue_mem_if.store m
);
	logic [DW-1:0] mem_q [2**AW];

	always_ff @(posedge sys_clk_i)
	begin
		if (m.we)
			mem_q[m.waddr] <= m.wdata;
		m.rdata <= mem_q[m.raddr];
	end
endmodule // queue_mem

// *** rtl/link_packet_tx.sv ***
// HDLC packet transmitter for the framer data link, with its register file.
// Assumes link_slot_i pulses once per data link bit position, at least a cycle apart.
//
// Added by the designer: the plain strobed port.
`include "lpt_consts.svh"
module link_packet_tx
	import lpt_pkg::*;
#(
	parameter int DEPTH          = 128,
	parameter int AW             = 7,
	parameter bit REPORT_CAPABLE = 1'b1
)(
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       e1_tx_arm_i,
	input  wire logic       link_slot_i,
	input  wire logic       link_bit_i,
	output logic            link_bit_o,
	input  wire logic       report_available_i,
	input  wire logic [7:0] report_byte_i,
	input  wire logic       report_last_i,
	output logic            report_take_o,
	output logic            irq_out_n_o
);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++)
			r[i] = v[15-i];
		return r;
	endfunction

	logic [7:0]    cfg_q;
	logic [6:0]    uth_q;
	logic [6:0]    lth_q;
	logic [4:0]    ien_q;
	logic [4:0]    ist_q;
	logic [7:0]    rdata_q;
	logic          below_q;
	logic          full_q;
	logic          rep_q;
	logic          abt_pend_q;
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0]   count_q;
	logic [AW:0]   pkt_cnt_q;
	logic          avail_q;
	logic [DEPTH-1:0] tag_q;
	tx_state_t     st_q;
	tx_state_t     st_d;
	logic [15:0]   shift_q;
	logic [4:0]    left_q;
	logic [2:0]    ones_q;
	logic [1:0]    fcnt_q;
	logic [1:0]    fcnt_d;
	logic          stuff_q;
	logic          crc_on_q;
	logic          src_pr_q;
	logic          pr_d;
	logic          last_q;
	logic          last_d;
	logic [15:0]   crc_q;
	logic          out_q;
	logic [15:0]   u_bits;
	logic [4:0]    u_len;
	logic          u_stuff;
	logic          u_crc;
	logic          u_pop;
	logic          u_take;
	logic          u_abort;
	logic          u_under;

	queue_mem_if #(.AW(AW), .DW(8)) qm ();

	queue_mem #(.AW(AW), .DW(8)) u_mem (
		.sys_clk_i (sys_clk_i),
		.m         (qm)
	);

	// Register decode
	wire sel_cfg = addr_i == `LPT_CFG_ADDR;
	wire sel_uth = addr_i == `LPT_UTH_ADDR;
	wire sel_lth = addr_i == `LPT_LTH_ADDR;
	wire sel_ien = addr_i == `LPT_IEN_ADDR;
	wire sel_ist = addr_i == `LPT_IST_ADDR;
	wire sel_txb = addr_i == `LPT_TXB_ADDR;
	wire wr_cfg  = wr_i & sel_cfg;
	wire wr_txb  = wr_i & sel_txb;
	wire wr_ist  = wr_i & sel_ist;
	wire rd_ist  = rd_i & sel_ist;

	wire en      = cfg_q[`LPT_B_EN];
	wire crc_en  = cfg_q[`LPT_B_CRC];
	wire abort_request     = cfg_q[`LPT_B_ABT];
	wire share   = cfg_q[`LPT_B_SHARE];
	wire report_insert_enable    = cfg_q[`LPT_B_REPORT_INSERT_ENABLE] & REPORT_CAPABLE;

	// Queue bookkeeping
	wire         full     = count_q == DEPTH_C;
	wire         push     = wr_txb & ~full;
	wire         over_evt = wr_txb & full;
	wire [AW-1:0] last_wr = wptr_q - 1'b1;
	wire         mark     = wr_cfg & wdata_i[`LPT_B_EOM] & (count_q != '0) & ~tag_q[last_wr];
	wire         avail    = avail_q & (count_q != '0);
	wire         q_tag    = tag_q[rptr_q];
	wire [7:0]   q_byte   = qm.rdata;

	// Serializer step
	wire         step      = en & link_slot_i;
	wire         stuff_now = stuff_q & (ones_q == `LPT_STUFF_RUN);
	wire         ld        = (left_q == '0) & ~stuff_now;
	wire [15:0]  cur       = ld ? u_bits : shift_q;
	wire         cur_stuff = ld ? u_stuff : stuff_q;
	wire         cur_crc   = ld ? u_crc : crc_on_q;
	wire         new_bit   = stuff_now ? 1'b0 : cur[0];
	wire         take      = step & ld;
	wire         pop       = take & u_pop;
	wire [15:0]  crc_next  = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ cur[0]) ? `LPT_CRC_POLY : '0);

	// Frame gating
	wire [1:0]   need      = share ? 2'd1 : 2'd2;
	wire         abort_on  = abort_request | abt_pend_q;
	wire         pr_go     = report_insert_enable & report_available_i;
	wire         go        = e1_tx_arm_i & avail
		& ((count_q > {1'b0, uth_q}) | (pkt_cnt_q != '0));
	wire         frame_ok  = (fcnt_q != 2'd3) & (fcnt_q >= need);
	wire [1:0]   fcnt_inc  = (fcnt_q == 2'd3) ? 2'd1 : ((fcnt_q == 2'd2) ? 2'd2 : fcnt_q + 2'd1);
	// Hold the queue flushed while abort stands between frames
	wire         flush     = cfg_q[`LPT_B_FLUSH] | (take & u_abort)
		| (abort_request & (st_q == TX_IDLE));

	// Status
	wire         below     = (count_q == '0) | (count_q < {1'b0, lth_q});
	wire [4:0]   ist_set   = {report_available_i & ~rep_q, full & ~full_q, over_evt,
		take & u_under, below & ~below_q};
	wire [4:0]   ist_clr   = rd_ist ? `LPT_IST_ALL
		: (wr_ist ? 5'(1 << `LPT_B_UNDER) : '0);
	wire [7:0]   rd_mux    = sel_cfg ? cfg_q
		: sel_uth ? {1'b0, uth_q}
		: sel_lth ? {1'b0, lth_q}
		: sel_ien ? {3'b000, ien_q}
		: sel_ist ? {1'b0, full, below, ist_q}
		: 8'h00;

	assign qm.we    = push;
	assign qm.waddr = wptr_q;
	assign qm.wdata = wdata_i;
	assign qm.raddr = rptr_q;

	assign rdata_o       = rdata_q;
	assign link_bit_o    = out_q;
	assign report_take_o = take & u_take;
	assign irq_out_n_o   = ~|(ist_q & ien_q);

	// Next unit to serialize, chosen at each unit boundary
	always_comb
	begin
		u_bits  = `LPT_FLAG;
		u_len   = `LPT_BYTE_BITS;
		u_stuff = 1'b0;
		u_crc   = 1'b0;
		u_pop   = 1'b0;
		u_take  = 1'b0;
		u_abort = 1'b0;
		u_under = 1'b0;
		st_d    = st_q;
		fcnt_d  = fcnt_q;
		pr_d    = src_pr_q;
		last_d  = last_q;
		unique case (st_q)
			TX_IDLE:
			begin
				if (pr_go && fcnt_q == 2'd2)
				begin
					u_bits  = {8'h00, report_byte_i};
					u_stuff = 1'b1;
					u_crc   = 1'b1;
					u_take  = 1'b1;
					st_d    = TX_BODY;
					pr_d    = 1'b1;
					last_d  = report_last_i;
				end
				else if (pr_go)
					fcnt_d = fcnt_inc;
				else if (abort_on && fcnt_q >= need)
				begin
					u_bits  = `LPT_ABORT;
					u_abort = 1'b1;
					fcnt_d  = 2'd3;
				end
				else if (go && frame_ok && !abort_request)
				begin
					u_bits  = {8'h00, q_byte};
					u_stuff = 1'b1;
					u_crc   = 1'b1;
					u_pop   = 1'b1;
					st_d    = TX_BODY;
					pr_d    = 1'b0;
					last_d  = q_tag;
				end
				else
					fcnt_d = fcnt_inc;
			end
			TX_BODY:
			begin
				if (last_q && crc_en)
				begin
					u_bits  = rev16(~crc_q);
					u_len   = `LPT_FCS_BITS;
					u_stuff = 1'b1;
					st_d    = TX_FCS;
				end
				else if (last_q)
				begin
					st_d   = TX_IDLE;
					fcnt_d = 2'd1;
				end
				else if (src_pr_q)
				begin
					u_bits  = {8'h00, report_byte_i};
					u_stuff = 1'b1;
					u_crc   = 1'b1;
					u_take  = 1'b1;
					last_d  = report_last_i;
				end
				else if (abort_on)
				begin
					u_bits  = `LPT_ABORT;
					u_abort = 1'b1;
					st_d    = TX_IDLE;
					fcnt_d  = 2'd3;
				end
				else if (avail)
				begin
					u_bits  = {8'h00, q_byte};
					u_stuff = 1'b1;
					u_crc   = 1'b1;
					u_pop   = 1'b1;
					last_d  = q_tag;
				end
				else
				begin
					u_bits  = `LPT_ABORT;
					u_abort = 1'b1;
					u_under = 1'b1;
					st_d    = TX_IDLE;
					fcnt_d  = 2'd3;
				end
			end
			TX_FCS:
			begin
				st_d   = TX_IDLE;
				fcnt_d = 2'd1;
			end
			default:
				st_d = TX_IDLE;
		endcase
	end

	// Control and status registers
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cfg_q      <= `LPT_CFG_RST;
			uth_q      <= `LPT_UTH_RST;
			lth_q      <= `LPT_LTH_RST;
			ien_q      <= `LPT_IEN_RST;
			ist_q      <= '0;
			rdata_q    <= '0;
			below_q    <= 1'b1;
			full_q     <= 1'b0;
			rep_q      <= 1'b0;
			abt_pend_q <= 1'b0;
		end
		else
		begin
			if (wr_cfg)
				cfg_q <= wdata_i & `LPT_CFG_MASK;
			else if (wr_txb)
				cfg_q[`LPT_B_EOM] <= 1'b0;
			if (wr_i && sel_uth)
				uth_q <= wdata_i[6:0];
			if (wr_i && sel_lth)
				lth_q <= wdata_i[6:0];
			if (wr_i && sel_ien)
				ien_q <= wdata_i[4:0];
			ist_q      <= (ist_q & ~ist_clr) | ist_set;
			rdata_q    <= rd_i ? rd_mux : 8'h00;
			below_q    <= below;
			full_q     <= full;
			rep_q      <= report_available_i;
			// A new request outlives a quick clear so that one abort still goes out
			abt_pend_q <= (wr_cfg & wdata_i[`LPT_B_ABT] & ~abort_request)
				| (abt_pend_q & ~(take & u_abort));
		end
	end

	// Queue pointers, fill level and end marks
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wptr_q    <= '0;
			rptr_q    <= '0;
			count_q   <= '0;
			pkt_cnt_q <= '0;
			avail_q   <= 1'b0;
			tag_q     <= '0;
		end
		else if (flush)
		begin
			wptr_q    <= '0;
			rptr_q    <= '0;
			count_q   <= '0;
			pkt_cnt_q <= '0;
			avail_q   <= 1'b0;
		end
		else
		begin
			wptr_q    <= wptr_q + AW'(push);
			rptr_q    <= rptr_q + AW'(pop);
			count_q   <= count_q + (AW+1)'(push) - (AW+1)'(pop);
			pkt_cnt_q <= pkt_cnt_q + (AW+1)'(mark) - (AW+1)'(pop & q_tag);
			// Delayed one cycle so the registered memory read has settled
			avail_q   <= count_q != '0;
			if (push)
				tag_q[wptr_q] <= 1'b0;
			if (mark)
				tag_q[last_wr] <= 1'b1;
		end
	end

	// Serializer
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_q     <= TX_IDLE;
			shift_q  <= '0;
			left_q   <= '0;
			ones_q   <= '0;
			fcnt_q   <= '0;
			stuff_q  <= 1'b0;
			crc_on_q <= 1'b0;
			src_pr_q <= 1'b0;
			last_q   <= 1'b0;
			crc_q    <= `LPT_CRC_INIT;
			out_q    <= 1'b0;
		end
		else
		begin
			out_q <= step ? new_bit : link_bit_i;
			if (!en)
			begin
				st_q    <= TX_IDLE;
				left_q  <= '0;
				ones_q  <= '0;
				fcnt_q  <= '0;
				stuff_q <= 1'b0;
			end
			else if (step && stuff_now)
				ones_q <= '0;
			else if (step)
			begin
				shift_q <= cur >> 1;
				left_q  <= (ld ? u_len : left_q) - 5'd1;
				ones_q  <= (cur_stuff && cur[0]) ? ones_q + 3'd1 : 3'd0;
				if (cur_crc)
					crc_q <= crc_next;
				else if (ld)
					crc_q <= `LPT_CRC_INIT;
				if (ld)
				begin
					st_q     <= st_d;
					fcnt_q   <= fcnt_d;
					src_pr_q <= pr_d;
					last_q   <= last_d;
					stuff_q  <= u_stuff;
					crc_on_q <= u_crc;
				end
			end
		end
	end
endmodule // link_packet_tx

// *** tb/lpt_properties.sv ***
// Port-level checks of the link packet transmitter.
// Assumes binding into link_packet_tx; it mirrors the control writes itself.
`include "lpt_consts.svh"
module lpt_properties (
	input wire logic       sys_clk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       link_slot_i,
	input wire logic       link_bit_i,
	input wire logic       link_bit_o,
	input wire logic       report_take_o,
	input wire logic       irq_out_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cfg_q;
	logic [4:0] ien_q;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cfg_q <= `LPT_CFG_RST;
			ien_q <= `LPT_IEN_RST;
		end
		else if (wr_i && addr_i == `LPT_CFG_ADDR)
			cfg_q <= wdata_i;
		else if (wr_i && addr_i == `LPT_IEN_ADDR)
			ien_q <= wdata_i[4:0];
	end
	off_pass_a: assert property (
		!$past(cfg_q[0]) && !$past(sys_rst_i) |-> link_bit_o == $past(link_bit_i))
		else $error("backplane bit altered while off");
	gap_pass_a: assert property (
		!$past(link_slot_i) && !$past(sys_rst_i) |-> link_bit_o == $past(link_bit_i))
		else $error("backplane bit altered outside slot");
	irq_mask_a: assert property (ien_q == 5'h00 |-> irq_out_n_o)
		else $error("interrupt with all enables off");
	take_off_a: assert property (!cfg_q[5] |-> !report_take_o)
		else $error("report taken while insertion off");
	take_slot_a: assert property (report_take_o |-> link_slot_i)
		else $error("report taken outside a slot");
	take_once_a: assert property (report_take_o |=> !report_take_o)
		else $error("report take longer than a cycle");
	ien_read_a: assert property (
		$past(rd_i) && $past(addr_i) == `LPT_IEN_ADDR |-> rdata_o == {3'h0, $past(ien_q)})
		else $error("enable readback wrong");
	cfg_read_a: assert property (
		$past(rd_i) && $past(addr_i) == `LPT_CFG_ADDR
		|-> (rdata_o & 8'hE7) == ($past(cfg_q) & 8'hE7))
		else $error("config readback wrong");
	cover property (report_take_o);
	cover property (!irq_out_n_o);
	cover property ($past(rd_i) && rdata_o != 8'h00);
endmodule // lpt_properties

bind link_packet_tx lpt_properties u_props (.*);

// *** tb/link_far_end.sv ***
// Far end of the data link: slot strobe, backplane bits, report source.
// Assumes the transmitter clock; slots come every GAP cycles.
module link_far_end #(
	parameter int GAP = 4
)(
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       go_i,
	input  wire logic       take_i,
	output logic            slot_o,
	output logic            bp_o,
	output logic            avail_o,
	output logic      [7:0] byte_o,
	output logic            last_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int   cnt_q;
	logic idx_q;
	logic done_q;
	assign slot_o  = (cnt_q == 0);
	assign avail_o = go_i && !done_q;
	assign byte_o  = idx_q ? 8'hFF : 8'h3C;
	assign last_o  = idx_q;
	// Backplane toggles every cycle so a stale pass-through is caught
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cnt_q  <= 0;
			bp_o   <= 1'b0;
			idx_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
			bp_o   <= ~bp_o;
			idx_q  <= go_i && (idx_q || take_i);
			done_q <= go_i && (done_q || (take_i && idx_q));
		end
	end
endmodule // link_far_end

// *** tb/testbench.sv ***
// Register-driven tests of the link packet transmitter with a frame decoder.
// Assumes link_far_end as the data link far end.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, arm = 1'b0, go = 1'b0;
	logic  [7:0] addr = 8'h00, wdat = 8'h00, rdat;
	logic  [7:0] dflt [4] = '{8'h82, 8'h40, 8'h07, 8'h00};
	logic [63:0] fr = '0, got = '0;
	logic        slot_d = 1'b0, inf = 1'b0;
	wire         slot, bp, lbit, avail, last, take, irq_n;
	wire   [7:0] rbyte;
	int          n_errors = 0, cmp_count = 0, ones = 0, nb = 0, glen = 0, n_fr = 0, n_ab = 0;
	always #25 clk = ~clk;
	link_packet_tx u_dut (.sys_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdat),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdat), .e1_tx_arm_i(arm), .link_slot_i(slot),
		.link_bit_i(bp), .link_bit_o(lbit), .report_available_i(avail),
		.report_byte_i(rbyte), .report_last_i(last), .report_take_o(take),
		.irq_out_n_o(irq_n));
	link_far_end #(.GAP(4)) u_far (.sys_clk_i(clk), .sys_rst_i(rst), .go_i(go),
		.take_i(take), .slot_o(slot), .bp_o(bp), .avail_o(avail), .byte_o(rbyte),
		.last_o(last));
	// Decoder: drops stuffed zeros, counts frames and aborts
	always @(posedge clk)
	begin
		slot_d <= slot;
		if (slot_d && lbit)
		begin
			ones++;
			n_ab += (ones == 7);
			inf = inf && ones < 7;
			if (nb < 64)
				fr[nb] = 1'b1;
			nb++;
		end
		else if (slot_d)
		begin
			if (ones == 6)
			begin
				if (inf && nb > 7)
				begin
					got = fr;
					glen = nb - 7;
					n_fr++;
				end
				inf = 1'b1;
				nb = 0;
			end
			else if (ones != 5)
			begin
				if (nb < 64)
					fr[nb] = 1'b0;
				nb++;
			end
			ones = 0;
		end
	end
	function automatic logic [15:0] fcs(input logic [15:0] d, input int n);
		logic [15:0] c;
		logic [15:0] r;
		c = 16'hFFFF;
		for (int i = 0; i < n; i++)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
		for (int i = 0; i < 16; i++)
			r[i] = ~c[15 - i];
		return r;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wait_fr(input int k);
		for (int t = 0; t < 4000 && n_fr < k; t++)
			@(posedge clk);
	endtask
	initial
	begin
		#3000000;
		n_errors++;
		conclude();
	end
	initial
	begin
		logic [7:0] d;
		int         k;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rd_reg(8'hA8 + 8'(i), d);
			check(d, dflt[i]);
		end
		rd_reg(8'hB0, d);
		check(d, 8'h00);
		rd_reg(8'hAC, d);
		check(d & 8'h60, 8'h20);
		arm <= 1'b1;
		wr_reg(8'hA8, 8'h83);
		repeat (200) @(posedge clk);
		check(inf, 1'b1);
		check(16'(n_fr + n_ab), 16'h0);
		for (int c = 0; c < 2; c++)
		begin
			wr_reg(8'hA8, c ? 8'h01 : 8'h83);
			wr_reg(8'hAD, 8'hF9);
			wr_reg(8'hA8, c ? 8'h09 : 8'h8B);
			wait_fr(c + 1);
			check(16'(glen), c ? 16'd8 : 16'd24);
			check(got[7:0], 8'hF9);
			if (c == 0)
				check(got[23:8], fcs(16'h00F9, 8));
		end
		// Disarmed and disabled so the fill cannot start sending
		arm <= 1'b0;
		wr_reg(8'hA8, 8'h8A);
		rd_reg(8'hAC, d);
		for (int i = 0; i < 127; i++)
			wr_reg(8'hAD, 8'(i));
		// End mark was set with an empty queue; the first data write must drop it
		rd_reg(8'hA8, d);
		check(d & 8'h08, 8'h00);
		rd_reg(8'hAC, d);
		check(d & 8'h48, 8'h00);
		wr_reg(8'hAD, 8'h7F);
		rd_reg(8'hAC, d);
		check(d & 8'h4C, 8'h48);
		wr_reg(8'hAB, 8'h04);
		#1 check(irq_n, 1'b1);
		wr_reg(8'hAD, 8'hAA);
		repeat (2) @(posedge clk);
		#1 check(irq_n, 1'b0);
		rd_reg(8'hAC, d);
		check(d & 8'h44, 8'h44);
		check(irq_n, 1'b1);
		wr_reg(8'hA8, 8'hC2);
		wr_reg(8'hA8, 8'h82);
		rd_reg(8'hAC, d);
		check(d & 8'h61, 8'h21);
		arm <= 1'b1;
		wr_reg(8'hA8, 8'h83);
		for (int i = 0; i < 10; i++)
			wr_reg(8'hAD, 8'hF0);
		rd_reg(8'hAC, d);
		check(d & 8'h20, 8'h00);
		k = n_ab;
		// Ten bytes sit below the threshold: a start would end in an underrun abort
		repeat (400) @(posedge clk);
		check(16'(n_ab), 16'(k));
		wr_reg(8'hA8, 8'h87);
		repeat (300) @(posedge clk);
		check(n_ab > k + 2, 1'b1);
		rd_reg(8'hAC, d);
		check(d & 8'h20, 8'h20);
		wr_reg(8'hA8, 8'h83);
		wr_reg(8'hAA, 8'h00);
		wr_reg(8'hA9, 8'h00);
		wr_reg(8'hAB, 8'h02);
		wr_reg(8'hAD, 8'h81);
		for (int t = 0; t < 4000 && irq_n; t++)
			@(posedge clk);
		check(irq_n, 1'b0);
		wr_reg(8'hAC, 8'h00);
		#1 check(irq_n, 1'b1);
		// Sending starts at two bytes and must carry on to the marked third
		wr_reg(8'hA9, 8'h01);
		k = n_fr + 1;
		wr_reg(8'hAD, 8'h11);
		wr_reg(8'hAD, 8'h22);
		wr_reg(8'hAD, 8'h33);
		wr_reg(8'hA8, 8'h8B);
		wait_fr(k);
		check(16'(glen), 16'd40);
		check(got[15:0], 16'h2211);
		check(got[23:16], 8'h33);
		wr_reg(8'hAB, 8'h10);
		k = n_fr + 1;
		go <= 1'b1;
		repeat (200) @(posedge clk);
		check(16'(n_fr), 16'(k - 1));
		check(irq_n, 1'b0);
		wr_reg(8'hA8, 8'hA3);
		wait_fr(k);
		check(16'(glen), 16'd32);
		check(got[15:0], 16'hFF3C);
		check(got[31:16], fcs(16'hFF3C, 16));
		go <= 1'b0;
		rd_reg(8'hAC, d);
		check(d & 8'h10, 8'h10);
		conclude();
	end
endmodule // testbench
